//--- include/mgi_regs.vh
`ifndef MGI_REGS_VH
`define MGI_REGS_VH
// register offsets on the primary register port
`define MGI_ADDR_ERROR_FLAGS 8'h02
`define MGI_ADDR_DATA_FIRST 8'h04
`define MGI_ADDR_DATA_LAST 8'h17
`define MGI_ADDR_STATUS 8'h1b
`define MGI_ADDR_MAG_CONFIG 8'h44
`define MGI_ADDR_FIFO_CONFIG_HI 8'h47
`define MGI_ADDR_LINK_CONTROL 8'h4c
`define MGI_ADDR_LINK_READ_ADDR 8'h4d
`define MGI_ADDR_LINK_WRITE_ADDR 8'h4e
`define MGI_ADDR_LINK_WRITE_DATA 8'h4f
`define MGI_ADDR_COMMAND 8'h7e
// field positions
`define MGI_CTRL_SETUP_BIT 7
`define MGI_STATUS_BUSY_BIT 2
`define MGI_STATUS_DRDY_BIT 5
`define MGI_ERR_DRDY_BIT 7
`define MGI_FIFO_MAG_EN_BIT 5
// reset values
`define MGI_CTRL_RESET 8'h80
`define MGI_CONF_RESET 8'h0b
// command codes
`define MGI_CMD_SUSPEND 8'h18
`define MGI_CMD_NORMAL 8'h19
`define MGI_CMD_LOW_POWER 8'h1a
// power modes
`define MGI_PM_SUSPEND 2'h0
`define MGI_PM_NORMAL 2'h1
`define MGI_PM_LOW_POWER 2'h2
// timing: ticks of 1 us from a 250 MHz clock
`define MGI_CLK_MHZ 250
`define MGI_TICK_CYCLES 8'd250
// fastest rate code 0x0b is 800 Hz, i.e. 1250 us; codes 1 to 0x0a double it per step below, code 0 gives 1250 us
`define MGI_ODR_BASE_US 21'd1250
// offset step per field unit, in microseconds; code 0 selects the maximum
`define MGI_OFFSET_STEP_US 21'd250
`define MGI_OFFSET_MAX_CODE 21'd16
`endif

//--- verilog/mgi_data_store.v
`timescale 1ns/10ps
// 24-byte data block; registered read data
module mgi_data_store (
    input wire ref_clk, // system clock
    input wire wr_en, // write strobe
    input wire [4:0] wr_index, // byte index written
    input wire [7:0] wr_data, // byte written
    input wire [4:0] rd_index, // byte index read
    output reg [7:0] rd_data // registered read byte
);
    reg [7:0] mem [0:23];

    // write port
    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_index] <= wr_data;
        end
    end

    // registered read port
    always @(posedge ref_clk) begin
        rd_data <= mem[rd_index];
    end
endmodule // mgi_data_store

//--- verilog/mgi_mag_bridge.v
`timescale 1ns/10ps
`include "mgi_regs.vh"
// Summary of operation
// - control bit 7 high selects setup mode
// - setup write to read address launches read
// - read fetches burst-selected byte count into data, or into fifo when enabled
// - write address launches single-byte indirect write
// - busy set on launch, cleared on completion
// - operate only in low power or normal
// - wait offset delay; code zero is maximum
// - data-mode rate follows rate field
// - data mode triggers forced measurements itself
// - data ready set by data, cleared by read
// - missing magnetometer ready sets error flag
// - command codes select interface power mode
// - results go to data or to fifo
module mgi_mag_bridge (
    input wire ref_clk, // 250 MHz clock
    input wire sys_rst, // synchronous reset, high
    input wire reg_wr, // host register write strobe
    input wire reg_rd, // host register read strobe
    input wire [7:0] reg_addr, // host register address
    input wire [7:0] reg_wdata, // host write data
    output reg [7:0] reg_rdata, // host read data, two cycles after reg_rd
    output wire mag_req, // magnetometer bus request
    output reg mag_write, // request is a write
    output reg [7:0] mag_addr, // magnetometer register address
    output reg [7:0] mag_wdata, // magnetometer write byte
    output reg mag_trigger, // forced-measurement trigger pulse
    input wire mag_ack, // magnetometer answers one byte
    input wire [7:0] mag_rdata, // magnetometer read byte
    input wire mag_drdy, // magnetometer data ready
    output reg fifo_push, // result byte to fifo
    output reg [7:0] fifo_byte // fifo byte
);
    localparam ST_IDLE = 5'h01;
    localparam ST_XFER = 5'h02;
    localparam ST_WAIT = 5'h04;
    localparam ST_CHECK = 5'h08;
    localparam ST_PACE = 5'h10;

    reg [7:0] link_control;
    reg [7:0] link_read_addr;
    reg [7:0] link_write_addr;
    reg [7:0] link_write_data;
    reg [7:0] magnetometer_config;
    reg [7:0] fifo_config_hi;
    reg [1:0] power_mode;
    reg indirect_op_busy;
    reg drdy_flag;
    reg drdy_err;
    reg [4:0] state;
    reg manual_write;
    reg [3:0] byte_cnt;
    reg [3:0] byte_total;
    reg [7:0] tick_cnt;
    reg tick;
    reg [20:0] wait_us;
    reg [20:0] pace_us;
    wire [7:0] store_rdata;
    reg rd_data_pending;
    reg rd_other_pending;
    reg [7:0] rd_other;

    // byte count from the read burst field: 1, 2, 6 or 8
    function [3:0] burst_bytes;
        input [1:0] code;
        begin
            case (code)
                2'h0: burst_bytes = 4'h1;
                2'h1: burst_bytes = 4'h2;
                2'h2: burst_bytes = 4'h6;
                default: burst_bytes = 4'h8;
            endcase
        end
    endfunction

    // data-block address test, used by read decode and read-clear
    function in_data;
        input [7:0] a;
        begin
            in_data = (a >= `MGI_ADDR_DATA_FIRST) && (a <= `MGI_ADDR_DATA_LAST);
        end
    endfunction

    wire link_active = (power_mode == `MGI_PM_NORMAL) || (power_mode == `MGI_PM_LOW_POWER);
    wire setup_mode = link_control[`MGI_CTRL_SETUP_BIT];
    wire [3:0] offset_code = link_control[5:2];
    wire [20:0] offset_us = (offset_code == 4'h0) ?
        `MGI_OFFSET_MAX_CODE * `MGI_OFFSET_STEP_US :
        {17'h0, offset_code} * `MGI_OFFSET_STEP_US;
    wire [3:0] odr_code = magnetometer_config[3:0];
    wire [3:0] odr_shift = (odr_code > 4'hb || odr_code == 4'h0) ? 4'h0 : 4'hb - odr_code;
    wire [20:0] period_us = `MGI_ODR_BASE_US << odr_shift;
    wire to_fifo = fifo_config_hi[`MGI_FIFO_MAG_EN_BIT];
    wire store_wr = (state == ST_XFER) && mag_ack && !manual_write && !to_fifo;
    wire [4:0] store_rd_idx = reg_addr[4:0] - 5'h04;

    assign mag_req = (state == ST_XFER);

    mgi_data_store u_store (
        .ref_clk(ref_clk),
        .wr_en(store_wr),
        .wr_index({1'b0, byte_cnt}),
        .wr_data(mag_rdata),
        .rd_index(store_rd_idx),
        .rd_data(store_rdata)
    );

    // microsecond tick divider
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            tick_cnt <= 8'h00;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == `MGI_TICK_CYCLES - 8'd1);
            tick_cnt <= (tick_cnt == `MGI_TICK_CYCLES - 8'd1) ? 8'h00 : tick_cnt + 8'h01;
        end
    end

    // host-writable registers and power commands
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            link_control <= `MGI_CTRL_RESET;
            link_read_addr <= 8'h00;
            link_write_addr <= 8'h00;
            link_write_data <= 8'h00;
            magnetometer_config <= `MGI_CONF_RESET;
            fifo_config_hi <= 8'h00;
            power_mode <= `MGI_PM_SUSPEND;
        end else if (reg_wr) begin
            case (reg_addr)
                `MGI_ADDR_LINK_CONTROL: link_control <= reg_wdata;
                `MGI_ADDR_LINK_READ_ADDR: link_read_addr <= reg_wdata;
                `MGI_ADDR_LINK_WRITE_ADDR: link_write_addr <= reg_wdata;
                `MGI_ADDR_LINK_WRITE_DATA: link_write_data <= reg_wdata;
                `MGI_ADDR_MAG_CONFIG: magnetometer_config <= reg_wdata;
                `MGI_ADDR_FIFO_CONFIG_HI: fifo_config_hi <= reg_wdata;
                `MGI_ADDR_COMMAND: begin
                    case (reg_wdata)
                        `MGI_CMD_NORMAL: power_mode <= `MGI_PM_NORMAL;
                        `MGI_CMD_LOW_POWER: power_mode <= `MGI_PM_LOW_POWER;
                        `MGI_CMD_SUSPEND: power_mode <= `MGI_PM_SUSPEND;
                        default: power_mode <= power_mode;
                    endcase
                end
                default: link_control <= link_control;
            endcase
        end
    end

    wire launch_read = reg_wr && reg_addr == `MGI_ADDR_LINK_READ_ADDR;
    wire launch_write = reg_wr && reg_addr == `MGI_ADDR_LINK_WRITE_ADDR;
    reg reg_rd_was_data;
    wire read_clear = rd_data_pending && reg_rd_was_data;

    // transfer sequencer for manual and autonomous accesses
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            indirect_op_busy <= 1'b0;
            manual_write <= 1'b0;
            byte_cnt <= 4'h0;
            byte_total <= 4'h1;
            mag_write <= 1'b0;
            mag_addr <= 8'h00;
            mag_wdata <= 8'h00;
            mag_trigger <= 1'b0;
            wait_us <= 21'h0;
            pace_us <= 21'h0;
            drdy_flag <= 1'b0;
            drdy_err <= 1'b0;
            fifo_push <= 1'b0;
            fifo_byte <= 8'h00;
        end else begin
            mag_trigger <= 1'b0;
            fifo_push <= 1'b0;
            // host read of the data block clears ready; a new set wins below
            if (read_clear) begin
                drdy_flag <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (link_active && setup_mode && (launch_read || launch_write)) begin
                        indirect_op_busy <= 1'b1;
                        manual_write <= launch_write;
                        mag_write <= launch_write;
                        mag_addr <= reg_wdata;
                        mag_wdata <= link_write_data;
                        byte_total <= launch_write ? 4'h1 : burst_bytes(link_control[1:0]);
                        byte_cnt <= 4'h0;
                        state <= ST_XFER;
                    end else if (link_active && !setup_mode) begin
                        mag_trigger <= 1'b1;
                        wait_us <= offset_us;
                        pace_us <= period_us;
                        state <= ST_WAIT;
                    end
                end
                ST_XFER: begin
                    if (mag_ack) begin
                        if (!manual_write && to_fifo) begin
                            fifo_push <= 1'b1;
                            fifo_byte <= mag_rdata;
                        end
                        mag_addr <= mag_addr + 8'h01;
                        byte_cnt <= byte_cnt + 4'h1;
                        if (byte_cnt + 4'h1 == byte_total) begin
                            if (indirect_op_busy) begin
                                indirect_op_busy <= 1'b0;
                                state <= ST_IDLE;
                            end else begin
                                drdy_flag <= 1'b1;
                                state <= ST_PACE;
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    if (tick) begin
                        pace_us <= (pace_us > 21'h1) ? pace_us - 21'h1 : 21'h1;
                        wait_us <= wait_us - 21'h1;
                        if (wait_us <= 21'h1) begin
                            state <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (!mag_drdy) begin
                        drdy_err <= 1'b1;
                    end
                    mag_write <= 1'b0;
                    mag_addr <= link_read_addr;
                    byte_total <= burst_bytes(link_control[1:0]);
                    byte_cnt <= 4'h0;
                    manual_write <= 1'b0;
                    state <= ST_XFER;
                end
                ST_PACE: begin
                    if (!link_active || setup_mode) begin
                        state <= ST_IDLE;
                    end else if (tick) begin
                        pace_us <= pace_us - 21'h1;
                        if (pace_us <= 21'h1) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // host read path; data block comes from the store a cycle later
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data_pending <= 1'b0;
            reg_rd_was_data <= 1'b0;
            rd_other_pending <= 1'b0;
            rd_other <= 8'h00;
            reg_rdata <= 8'h00;
        end else begin
            rd_data_pending <= reg_rd && in_data(reg_addr);
            reg_rd_was_data <= reg_rd && in_data(reg_addr);
            rd_other_pending <= reg_rd && !in_data(reg_addr);
            case (reg_addr)
                `MGI_ADDR_ERROR_FLAGS: rd_other <= {drdy_err, 7'h00};
                `MGI_ADDR_STATUS: rd_other <= {2'h0, drdy_flag, 2'h0, indirect_op_busy, 2'h0};
                `MGI_ADDR_MAG_CONFIG: rd_other <= magnetometer_config;
                `MGI_ADDR_FIFO_CONFIG_HI: rd_other <= fifo_config_hi;
                `MGI_ADDR_LINK_CONTROL: rd_other <= link_control;
                `MGI_ADDR_LINK_READ_ADDR: rd_other <= link_read_addr;
                `MGI_ADDR_LINK_WRITE_ADDR: rd_other <= link_write_addr;
                `MGI_ADDR_LINK_WRITE_DATA: rd_other <= link_write_data;
                default: rd_other <= 8'h00;
            endcase
            if (rd_data_pending) begin
                reg_rdata <= store_rdata;
            end else if (rd_other_pending) begin
                reg_rdata <= rd_other;
            end
        end
    end
endmodule // mgi_mag_bridge

//--- verification/mgi_bridge_sva.sv
`timescale 1ns/10ps
// port-level checks of the magnetometer bridge
module mgi_bridge_sva (
    input wire logic ref_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic reg_wr, // host write
    input wire logic reg_rd, // host read
    input wire logic [7:0] reg_addr, // host address
    input wire logic [7:0] reg_wdata, // host data
    input wire logic [7:0] reg_rdata, // read data
    input wire logic mag_req, // link request
    input wire logic mag_write, // link write
    input wire logic [7:0] mag_addr, // link address
    input wire logic [7:0] mag_wdata, // link byte
    input wire logic mag_trigger, // measurement start
    input wire logic mag_ack // link answer
);
    logic [7:0] wr_byte, wr_addr, rd_addr;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // shadows of the link address and data registers
    always_ff @(posedge ref_clk) begin
        if (reg_wr && reg_addr == 8'h4f) wr_byte <= reg_wdata;
        if (reg_wr && reg_addr == 8'h4e) wr_addr <= reg_wdata;
        if (reg_wr && reg_addr == 8'h4d) rd_addr <= reg_wdata;
    end
    a_req_hold: assert property (mag_req && !mag_ack |=> mag_req && $stable(mag_addr))
        else $error("link request changed before answer");
    a_wr_single: assert property (mag_req && mag_write && mag_ack |=> !mag_req)
        else $error("write went past one byte");
    a_wr_content: assert property ($rose(mag_req) && mag_write |->
        mag_addr == wr_addr && mag_wdata == wr_byte)
        else $error("link write carries wrong address or byte");
    a_rd_start: assert property ($rose(mag_req) && !mag_write |->
        8'(mag_addr - rd_addr) < 8'h08)
        else $error("link read outside burst window");
    a_trig_pulse: assert property (mag_trigger |=> !mag_trigger)
        else $error("trigger longer than one cycle");
    a_trig_gap: assert property (mag_trigger |=> !mag_req [*8])
        else $error("read too soon after trigger");
    a_rst_quiet: assert property ($fell(sys_rst) |-> (!mag_req && !mag_trigger) [*4])
        else $error("link active while suspended");
    a_rdata_hold: assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule // mgi_bridge_sva

bind mgi_mag_bridge mgi_bridge_sva u_sva (.ref_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .mag_req, .mag_write, .mag_addr, .mag_wdata, .mag_trigger, .mag_ack);

//--- verification/mgi_mag_model.sv
`timescale 1ns/10ps
// behavioural magnetometer core behind the link
module mgi_mag_model (
    input wire logic ref_clk, // clock
    input wire logic [3:0] lat, // answer delay
    input wire logic drdy_en, // ready after trigger
    input wire logic mag_req, // request
    input wire logic mag_write, // write request
    input wire logic [7:0] mag_addr, // address
    input wire logic [7:0] mag_wdata, // write byte
    input wire logic mag_trigger, // measurement start
    output logic mag_ack, // byte answered
    output logic [7:0] mag_rdata, // read byte
    output logic mag_drdy // data ready
);
    logic [7:0] mem [256];
    logic [3:0] cnt = 4'h0;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
        mag_ack = 1'b0;
        mag_drdy = 1'b0;
        mag_rdata = 8'h00;
    end
    // one byte per answer after lat cycles; data line toggles when idle
    always @(posedge ref_clk) begin
        mag_ack <= 1'b0;
        mag_rdata <= ~mag_rdata;
        if (mag_req && !mag_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt == lat) begin
                mag_ack <= 1'b1;
                cnt <= 4'h0;
                mag_rdata <= mem[mag_addr];
                if (mag_write) mem[mag_addr] <= mag_wdata;
            end
        end else cnt <= 4'h0;
        if (mag_trigger) mag_drdy <= drdy_en;
    end
endmodule // mgi_mag_model

//--- verification/tb_mgi_mag_bridge.sv
`timescale 1ns/10ps
// host-side bench for the magnetometer bridge
module tb_mgi_mag_bridge;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, drdy_en = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mag_addr, mag_wdata;
    logic [7:0] mag_rdata, fifo_byte, d;
    logic mag_req, mag_write, mag_trigger, mag_ack, mag_drdy, fifo_push;
    logic [3:0] lat = 4'h9;
    int fails = 0, n_compared = 0, n_ack = 0, n_push = 0, k, b;
    int n_exp[4] = '{1, 2, 6, 8};
    logic [7:0] cmds[3] = '{8'h19, 8'h1a, 8'h18};
    always #2 ref_clk = ~ref_clk;
    mgi_mag_bridge dut (.ref_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .mag_req, .mag_write, .mag_addr, .mag_wdata, .mag_trigger, .mag_ack, .mag_rdata,
        .mag_drdy, .fifo_push, .fifo_byte);
    mgi_mag_model u_mag (.ref_clk, .lat, .drdy_en, .mag_req, .mag_write, .mag_addr,
        .mag_wdata, .mag_trigger, .mag_ack, .mag_rdata, .mag_drdy);
    // count link answers and fifo pushes
    always @(posedge ref_clk) begin
        if (mag_ack === 1'b1) n_ack++;
        if (fifo_push === 1'b1) n_push++;
    end
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 d = reg_rdata;
    endtask
    // poll status until the busy bit drops
    task automatic poll();
        k = 0;
        rd(8'h1b);
        while (d[2] !== 1'b0 && k < 300) begin
            k++;
            rd(8'h1b);
        end
        chk("busy clear", {5'h0, d[2], 2'h0}, 8'h00);
    endtask
    // wait for a link signal, counting cycles
    task automatic wait_hi(ref logic s, input int lim);
        k = 0;
        while (s !== 1'b1 && k < lim) begin
            @(posedge ref_clk);
            #1 k++;
        end
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        fails++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h4c);
        chk("link control", d, 8'h80);
        rd(8'h44);
        chk("mag config", d, 8'h0b);
        rd(8'h30);
        chk("unmapped", d, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 3; i++) begin
            wr(8'h7e, cmds[i]);
            repeat (20) @(posedge ref_clk);
            b = n_ack;
            wr(8'h4f, 8'ha0 + 8'(i));
            wr(8'h4e, 8'h60 + 8'(i));
            rd(8'h1b);
            chk("busy", {5'h0, d[2], 2'h0}, i < 2 ? 8'h04 : 8'h00);
            poll();
            chk("write acks", 8'(n_ack - b), i < 2 ? 8'h01 : 8'h00);
            chk("mag byte", u_mag.mem[8'h60 + i], i < 2 ? 8'ha0 + 8'(i) : 8'h5e);
        end
        $display("test power modes done");
        wr(8'h7e, 8'h19);
        repeat (20) @(posedge ref_clk);
        for (int c = 0; c < 4; c++) begin
            b = n_ack;
            wr(8'h4c, 8'h80 | 8'(c));
            wr(8'h4d, 8'h40);
            poll();
            chk("read acks", 8'(n_ack - b), 8'(n_exp[c]));
            for (int j = 0; j < n_exp[c]; j++) begin
                rd(8'h04 + 8'(j));
                chk("read byte", d, 8'(8'h40 + j) ^ 8'h3c);
            end
        end
        $display("test burst reads done");
        wr(8'h4f, 8'h02);
        wr(8'h4e, 8'h4c);
        poll();
        wr(8'h4d, 8'h42);
        poll();
        for (int j = 0; j < 8; j++) u_mag.mem[8'h42 + j] = 8'hc0 + 8'(j);
        drdy_en <= 1'b0;
        wr(8'h4c, 8'h07);
        wait_hi(mag_trigger, 2000);
        chk("trigger", {7'h0, mag_trigger}, 8'h01);
        wait_hi(mag_req, 70000);
        chk("offset wait", 8'(k >= 62240 && k <= 62520), 8'h01);
        k = 0;
        rd(8'h1b);
        while (d[5] !== 1'b1 && k < 300) begin
            k++;
            rd(8'h1b);
        end
        chk("data ready", {2'h0, d[5], 5'h0}, 8'h20);
        rd(8'h02);
        chk("ready error", d & 8'h80, 8'h80);
        for (int j = 0; j < 8; j++) begin
            rd(8'h04 + 8'(j));
            chk("acq byte", d, 8'hc0 + 8'(j));
        end
        rd(8'h1b);
        chk("ready cleared", d & 8'h20, 8'h00);
        chk("fifo pushes", 8'(n_push), 8'h00);
        chk("fifo byte", fifo_byte, 8'h00);
        $display("test data mode done");
        end_sim();
    end
endmodule // tb_mgi_mag_bridge
